// ### core/clock_gen_core.sv
// Configuration registers, divider banks and output crosspoint of the clock generator.
// Assumes a two-wire bus slave drives the byte register port on MCLK, and that
// reference and loop clocks arrive as pins slower than half of MCLK.
//
// Behaviour
// RULE1: Input division total is the 7-bit input divider field plus two.
// RULE2: Loop multiplier total equals twice (feedback base plus four) plus odd bit.
// RULE3: Feedback base: high two bits from gain register, low eight next register.
// RULE4: Odd bit is bit 7 of input divider register, field below.
// RULE5: Gain register top three bits are fixed; gain code sits in bits 4:2.
// RULE6: Programmer picks gain code from multiplier total ranges.
// RULE7: Programmer never loads gain codes 101, 110 or 111.
// RULE8: Programmer keeps multiplier total between 8 and 2055.
// RULE9: Programmer keeps divided input frequency at or above 250 kHz.
// RULE10: Programmer keeps loop oscillator between 100 MHz and 400 MHz.
// RULE11: Bank register bit 7 picks loop output or reference for the bank.
// RULE12: Bank divisor is the low seven bits; programmer uses 4 to 127.
// RULE13: Each output has a 3-bit source code; 000 reference, 111 reserved.
// RULE14: Codes 001, 010, 011: bank 1 variable, divide by 2, divide by 3.
// RULE15: Codes 100, 101, 110: bank 2 variable, divide by 2, divide by 4.
// RULE16: Programmer writes fixed low six bits with the last two source bits.
// RULE17: Bank 1 fixed outputs rise with the variable output when divisible.
// RULE18: Bank 2 fixed outputs rise with the variable output when divisible.
// RULE19: Programmer sets bank 1 divisor to 6 or multiple of four as needed.
// RULE20: Programmer sets an unused bank divisor to 8.
// RULE21: Each output has its own enable bit in bits 5:0; one enables.
// RULE22: Enable bits 0..5 map outputs 1..6; bits 7:6 read zero.
// RULE23: Source codes packed MSB first, output 1 to 6, ending bits 7:6.
// RULE24: A disabled output is held low without toggling.
// RULE25: Variable dividers count bank clock edges, period equals divisor, near half duty.
`timescale 1ns/1ps
module clock_gen_core
    import clock_gen_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RESET,
    input  wire logic        REF_CLK,
    input  wire logic        LOOP_CLK,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WRITE,
    output logic      [7:0]  REG_RDATA,
    output logic      [7:0]  INPUT_DIVISION_TOTAL,
    output logic      [11:0] LOOP_MULTIPLIER_TOTAL,
    output logic      [2:0]  LOOP_GAIN_CODE,
    output logic             PHASE_REFERENCE,
    output logic             LOW_RAIL_OUT1,
    output logic             LOW_RAIL_OUT2,
    output logic             LOW_RAIL_OUT3,
    output logic             LOW_RAIL_OUT4,
    output logic             MAIN_RAIL_OUT5,
    output logic             MAIN_RAIL_OUT6
);
    // --------
    // Register file
    // --------
    logic [7:0]  enable_reg, enable_next;
    logic [7:0]  bank1_reg, bank1_next;
    logic [7:0]  gain_reg, gain_next;
    logic [7:0]  feedback_low_reg, feedback_low_next;
    logic [7:0]  input_div_reg, input_div_next;
    logic [7:0]  source0_reg, source0_next;
    logic [7:0]  source1_reg, source1_next;
    logic [7:0]  source2_reg, source2_next;
    logic [7:0]  bank2_reg, bank2_next;
    logic [7:0]  rdata_reg, rdata_next;

    always_comb
    begin
        enable_next       = enable_reg;
        bank1_next        = bank1_reg;
        gain_next         = gain_reg;
        feedback_low_next = feedback_low_reg;
        input_div_next    = input_div_reg;
        source0_next      = source0_reg;
        source1_next      = source1_reg;
        source2_next      = source2_reg;
        bank2_next        = bank2_reg;
        if (REG_WRITE)
        begin
            unique case (REG_ADDR)
                OUTPUT_ENABLE_OFS: enable_next = {2'b00, REG_WDATA[ENABLE_MSB:0]};            // RULE21 RULE22
                BANK1_OFS:         bank1_next = REG_WDATA;
                LOOP_GAIN_OFS:     gain_next = {LOOP_GAIN_PRESET, REG_WDATA[GAIN_MSB:0]};     // RULE5
                FEEDBACK_LOW_OFS:  feedback_low_next = REG_WDATA;
                INPUT_DIVIDER_OFS: input_div_next = REG_WDATA;
                SOURCE_SEL0_OFS:   source0_next = REG_WDATA;
                SOURCE_SEL1_OFS:   source1_next = REG_WDATA;
                SOURCE_SEL2_OFS:   source2_next = REG_WDATA;
                BANK2_OFS:         bank2_next = REG_WDATA;
                default:           enable_next = enable_reg;
            endcase
        end
        unique case (REG_ADDR)
            OUTPUT_ENABLE_OFS: rdata_next = enable_reg;
            BANK1_OFS:         rdata_next = bank1_reg;
            LOOP_GAIN_OFS:     rdata_next = gain_reg;
            FEEDBACK_LOW_OFS:  rdata_next = feedback_low_reg;
            INPUT_DIVIDER_OFS: rdata_next = input_div_reg;
            SOURCE_SEL0_OFS:   rdata_next = source0_reg;
            SOURCE_SEL1_OFS:   rdata_next = source1_reg;
            SOURCE_SEL2_OFS:   rdata_next = source2_reg;
            BANK2_OFS:         rdata_next = bank2_reg;
            default:           rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            enable_reg       <= OUTPUT_ENABLE_RST;
            bank1_reg        <= BANK_RST;
            gain_reg         <= LOOP_GAIN_RST;
            feedback_low_reg <= FEEDBACK_LOW_RST;
            input_div_reg    <= INPUT_DIVIDER_RST;
            source0_reg      <= SOURCE_SEL_RST;
            source1_reg      <= SOURCE_SEL_RST;
            source2_reg      <= SOURCE_SEL2_RST;
            bank2_reg        <= BANK_RST;
            rdata_reg        <= 8'h00;
        end
        else
        begin
            enable_reg       <= enable_next;
            bank1_reg        <= bank1_next;
            gain_reg         <= gain_next;
            feedback_low_reg <= feedback_low_next;
            input_div_reg    <= input_div_next;
            source0_reg      <= source0_next;
            source1_reg      <= source1_next;
            source2_reg      <= source2_next;
            bank2_reg        <= bank2_next;
            rdata_reg        <= rdata_next;
        end
    end

    // --------
    // Loop settings
    // --------
    logic [9:0]  feedback_base_count;
    logic        feedback_odd_bit;
    logic [7:0]  input_total_next, input_total_reg;
    logic [11:0] mult_total_next, mult_total_reg;

    always_comb
    begin
        feedback_base_count = {gain_reg[FEEDBACK_HIGH_MSB:0], feedback_low_reg};                // RULE3
        feedback_odd_bit    = input_div_reg[ODD_BIT_POS];                                       // RULE4
        input_total_next    = {1'b0, input_div_reg[6:0]} + INPUT_DIV_OFFSET;                    // RULE1
        mult_total_next     = 12'(({2'b00, feedback_base_count} + FEEDBACK_OFFSET) << 1)
                            + {11'h000, feedback_odd_bit};                                      // RULE2
    end

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            input_total_reg <= 8'h00;
            mult_total_reg  <= 12'h000;
        end
        else
        begin
            input_total_reg <= input_total_next;
            mult_total_reg  <= mult_total_next;
        end
    end

    // --------
    // Pin synchronisers and edge ticks
    // --------
    logic [2:0] ref_sync_reg, ref_sync_next;
    logic [2:0] loop_sync_reg, loop_sync_next;
    logic       ref_tick, loop_tick, bank1_tick, bank2_tick;

    always_comb
    begin
        ref_sync_next  = {ref_sync_reg[1:0], REF_CLK};
        loop_sync_next = {loop_sync_reg[1:0], LOOP_CLK};
        ref_tick       = ref_sync_reg[1] && !ref_sync_reg[2];
        loop_tick      = loop_sync_reg[1] && !loop_sync_reg[2];
        bank1_tick     = bank1_reg[BANK_SOURCE_BIT] ? ref_tick : loop_tick;                      // RULE11
        bank2_tick     = bank2_reg[BANK_SOURCE_BIT] ? ref_tick : loop_tick;                      // RULE11
    end

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            ref_sync_reg  <= 3'h0;
            loop_sync_reg <= 3'h0;
        end
        else
        begin
            ref_sync_reg  <= ref_sync_next;
            loop_sync_reg <= loop_sync_next;
        end
    end

    // --------
    // Dividers
    // --------
    logic [7:0] src_level;
    logic       b1_wrap, b2_wrap;

    clk_divider #(.W(8)) u_input_div (.clk(MCLK), .rst(RESET), .tick(ref_tick), .restart(1'b0),
        .divisor(input_total_reg), .out_level(src_level[7]), .wrap());                          // RULE1
    clk_divider #(.W(7)) u_b1_var (.clk(MCLK), .rst(RESET), .tick(bank1_tick), .restart(1'b0),
        .divisor(bank1_reg[6:0]), .out_level(src_level[SRC_BANK1_VAR]), .wrap(b1_wrap));        // RULE12 RULE25
    clk_divider #(.W(7)) u_b1_div2 (.clk(MCLK), .rst(RESET), .tick(bank1_tick), .restart(b1_wrap),
        .divisor(FIXED_DIV2), .out_level(src_level[SRC_BANK1_DIV2]), .wrap());                   // RULE14 RULE17
    clk_divider #(.W(7)) u_b1_div3 (.clk(MCLK), .rst(RESET), .tick(bank1_tick), .restart(b1_wrap),
        .divisor(FIXED_DIV3), .out_level(src_level[SRC_BANK1_DIV3]), .wrap());                   // RULE14 RULE17
    clk_divider #(.W(7)) u_b2_var (.clk(MCLK), .rst(RESET), .tick(bank2_tick), .restart(1'b0),
        .divisor(bank2_reg[6:0]), .out_level(src_level[SRC_BANK2_VAR]), .wrap(b2_wrap));        // RULE12 RULE25
    clk_divider #(.W(7)) u_b2_div2 (.clk(MCLK), .rst(RESET), .tick(bank2_tick), .restart(b2_wrap),
        .divisor(FIXED_DIV2), .out_level(src_level[SRC_BANK2_DIV2]), .wrap());                   // RULE15 RULE18
    clk_divider #(.W(7)) u_b2_div4 (.clk(MCLK), .rst(RESET), .tick(bank2_tick), .restart(b2_wrap),
        .divisor(FIXED_DIV4), .out_level(src_level[SRC_BANK2_DIV4]), .wrap());                   // RULE15 RULE18

    assign src_level[SRC_REFERENCE] = ref_sync_reg[2];

    // --------
    // Output crosspoint and enables
    // --------
    logic [17:0] packed_codes;
    logic [5:0]  out_reg, out_next;
    logic [2:0]  code;

    always_comb
    begin
        packed_codes = {source0_reg, source1_reg, source2_reg[7:6]};                             // RULE23
        out_next     = 6'h00;
        code         = 3'h0;
        for (int i = 0; i < NUM_OUTPUTS; i++)
        begin
            code = packed_codes[17 - SOURCE_CODE_BITS * i -: SOURCE_CODE_BITS];
            if (enable_reg[i] && code != SRC_RESERVED)                                           // RULE13 RULE24
                out_next[i] = src_level[code];                                                   // RULE14 RULE15
        end
    end

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
            out_reg <= 6'h00;
        else
            out_reg <= out_next;
    end

    assign REG_RDATA             = rdata_reg;
    assign INPUT_DIVISION_TOTAL  = input_total_reg;
    assign LOOP_MULTIPLIER_TOTAL = mult_total_reg;
    assign LOOP_GAIN_CODE        = gain_reg[GAIN_MSB:GAIN_LSB];
    assign PHASE_REFERENCE       = src_level[7];
    assign LOW_RAIL_OUT1         = out_reg[0];                                                   // RULE22
    assign LOW_RAIL_OUT2         = out_reg[1];
    assign LOW_RAIL_OUT3         = out_reg[2];
    assign LOW_RAIL_OUT4         = out_reg[3];
    assign MAIN_RAIL_OUT5        = out_reg[4];
    assign MAIN_RAIL_OUT6        = out_reg[5];
endmodule : clock_gen_core

// ### core/clock_gen_pkg.sv
// Constants for the clock generator configuration and routing logic.
// Assumes byte-wide register access from a two-wire bus slave built elsewhere.
package clock_gen_pkg;
    // --------
    // Register offsets
    // --------
    localparam logic [7:0] OUTPUT_ENABLE_OFS   = 8'h09;
    localparam logic [7:0] BANK1_OFS           = 8'h0C;
    localparam logic [7:0] LOOP_GAIN_OFS       = 8'h40;
    localparam logic [7:0] FEEDBACK_LOW_OFS    = 8'h41;
    localparam logic [7:0] INPUT_DIVIDER_OFS   = 8'h42;
    localparam logic [7:0] SOURCE_SEL0_OFS     = 8'h44;
    localparam logic [7:0] SOURCE_SEL1_OFS     = 8'h45;
    localparam logic [7:0] SOURCE_SEL2_OFS     = 8'h46;
    localparam logic [7:0] BANK2_OFS           = 8'h47;

    // --------
    // Field positions
    // --------
    localparam int BANK_SOURCE_BIT    = 7;
    localparam int ODD_BIT_POS        = 7;
    localparam int GAIN_MSB           = 4;
    localparam int GAIN_LSB           = 2;
    localparam int FEEDBACK_HIGH_MSB  = 1;
    localparam int ENABLE_MSB         = 5;
    localparam int NUM_OUTPUTS        = 6;
    localparam int SOURCE_CODE_BITS   = 3;

    // --------
    // Fixed bits and reset values
    // --------
    localparam logic [2:0] LOOP_GAIN_PRESET    = 3'h6;
    localparam logic [7:0] OUTPUT_ENABLE_RST   = 8'h00;
    localparam logic [7:0] BANK_RST            = 8'h08;
    localparam logic [7:0] LOOP_GAIN_RST       = 8'hC0;
    localparam logic [7:0] FEEDBACK_LOW_RST    = 8'h00;
    localparam logic [7:0] INPUT_DIVIDER_RST   = 8'h00;
    localparam logic [7:0] SOURCE_SEL_RST      = 8'h00;
    localparam logic [7:0] SOURCE_SEL2_RST     = 8'h3F;

    // --------
    // Divider constants
    // --------
    localparam logic [7:0]  INPUT_DIV_OFFSET    = 8'h02;
    localparam logic [11:0] FEEDBACK_OFFSET     = 12'h004;
    localparam logic [6:0]  FIXED_DIV2          = 7'h02;
    localparam logic [6:0]  FIXED_DIV3          = 7'h03;
    localparam logic [6:0]  FIXED_DIV4          = 7'h04;

    // --------
    // Output source codes
    // --------
    typedef enum logic [2:0] {
        SRC_REFERENCE  = 3'h0,
        SRC_BANK1_VAR  = 3'h1,
        SRC_BANK1_DIV2 = 3'h2,
        SRC_BANK1_DIV3 = 3'h3,
        SRC_BANK2_VAR  = 3'h4,
        SRC_BANK2_DIV2 = 3'h5,
        SRC_BANK2_DIV4 = 3'h6,
        SRC_RESERVED   = 3'h7
    } source_code_t;
endpackage : clock_gen_pkg

// ### core/clk_divider.sv
// Tick-driven divider with near half duty output and restart for phase alignment.
// Assumes tick is a one-cycle pulse per rising edge of the bank clock.
`timescale 1ns/1ps
module clk_divider #(
    parameter int W = 7
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         tick,
    input  wire logic         restart,
    input  wire logic [W-1:0] divisor,
    output logic              out_level,
    output logic              wrap
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic         level_reg;
    logic         level_next;
    logic [W-1:0] limit;
    logic [W-1:0] half;

    // --------
    // Counter
    // --------
    always_comb
    begin
        limit = (divisor < W'(2)) ? W'(2) : divisor;
        half  = (limit >> 1) + W'(limit[0]);
        wrap  = tick && (count_reg >= W'(limit - W'(1)));
        count_next = count_reg;
        if (tick)
        begin
            if (restart || wrap)
                count_next = '0;
            else
                count_next = W'(count_reg + W'(1));
        end
        level_next = (count_next < half);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= '0;
            level_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            level_reg <= level_next;
        end
    end

    assign out_level = level_reg;
endmodule : clk_divider

// ### verif/clock_gen_core_sva.sv
// Checker for the clock generator core: register map, totals and output gating.
// Assumes it is bound to clock_gen_core and sees only the ports of that module.
`timescale 1ns/1ps
module clock_gen_core_sva
    import clock_gen_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RESET,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WRITE,
    input wire logic [7:0]  REG_RDATA,
    input wire logic [7:0]  INPUT_DIVISION_TOTAL,
    input wire logic [11:0] LOOP_MULTIPLIER_TOTAL,
    input wire logic [2:0]  LOOP_GAIN_CODE,
    input wire logic        PHASE_REFERENCE,
    input wire logic        LOW_RAIL_OUT1,
    input wire logic        LOW_RAIL_OUT2,
    input wire logic        LOW_RAIL_OUT3,
    input wire logic        LOW_RAIL_OUT4,
    input wire logic        MAIN_RAIL_OUT5,
    input wire logic        MAIN_RAIL_OUT6
);
    // --------
    // Enable shadow and age since last enable write
    // --------
    logic [5:0] en_reg;
    logic [5:0] en_next;
    logic [3:0] age_reg;
    logic [3:0] age_next;
    logic [5:0] outs;
    assign outs = {MAIN_RAIL_OUT6, MAIN_RAIL_OUT5, LOW_RAIL_OUT4, LOW_RAIL_OUT3, LOW_RAIL_OUT2, LOW_RAIL_OUT1};
    always_comb
    begin
        en_next  = en_reg;
        age_next = (age_reg == 4'hF) ? age_reg : age_reg + 4'h1;
        if (REG_WRITE && REG_ADDR == 8'h09)
        begin
            en_next  = REG_WDATA[5:0];
            age_next = 4'h0;
        end
    end
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            en_reg  <= 6'h00;
            age_reg <= 4'hF;
        end
        else
        begin
            en_reg  <= en_next;
            age_reg <= age_next;
        end
    end
    // --------
    // Assertions
    // --------
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    gain_fixed_a: assert property (!$past(RESET) && $past(REG_ADDR) == 8'h40 |-> REG_RDATA[7:5] == 3'h6)
        else $error("gain register top bits wrong");
    gain_code_a: assert property (REG_WRITE && REG_ADDR == 8'h40 |=> LOOP_GAIN_CODE == $past(REG_WDATA[4:2]))
        else $error("gain code not taken from bits 4:2");
    enable_top_a: assert property (!$past(RESET) && $past(REG_ADDR) == 8'h09 |-> REG_RDATA[7:6] == 2'h0)
        else $error("enable register top bits not zero");
    input_total_a: assert property (REG_WRITE && REG_ADDR == 8'h42
        |-> ##2 INPUT_DIVISION_TOTAL == {1'b0, $past(REG_WDATA[6:0], 2)} + 8'h02)
        else $error("input division total wrong");
    mult_low_a: assert property (REG_WRITE && REG_ADDR == 8'h41
        |-> ##2 LOOP_MULTIPLIER_TOTAL[8:1] == $past(REG_WDATA, 2) + 8'h04)
        else $error("multiplier total low part wrong");
    odd_bit_a: assert property (REG_WRITE && REG_ADDR == 8'h42
        |-> ##2 LOOP_MULTIPLIER_TOTAL[0] == $past(REG_WDATA[7], 2))
        else $error("odd bit not in multiplier total");
    total_range_a: assert property (!$past(RESET) |-> INPUT_DIVISION_TOTAL inside {[8'h02:8'h81]}
        && LOOP_MULTIPLIER_TOTAL inside {[12'h008:12'h807]})
        else $error("total outside its range");
    disabled_low_a: assert property (age_reg >= 4'h4 |-> (outs & ~en_reg) == 6'h00)
        else $error("disabled output not low");
    cover property (REG_WRITE && REG_ADDR == 8'h40);
    cover property ($rose(LOW_RAIL_OUT2) && $rose(LOW_RAIL_OUT3));
    cover property ($rose(MAIN_RAIL_OUT6));
endmodule : clock_gen_core_sva

bind clock_gen_core clock_gen_core_sva clock_gen_core_sva_i (.MCLK(MCLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE), .REG_RDATA(REG_RDATA),
    .INPUT_DIVISION_TOTAL(INPUT_DIVISION_TOTAL), .LOOP_MULTIPLIER_TOTAL(LOOP_MULTIPLIER_TOTAL),
    .LOOP_GAIN_CODE(LOOP_GAIN_CODE), .PHASE_REFERENCE(PHASE_REFERENCE), .LOW_RAIL_OUT1(LOW_RAIL_OUT1),
    .LOW_RAIL_OUT2(LOW_RAIL_OUT2), .LOW_RAIL_OUT3(LOW_RAIL_OUT3), .LOW_RAIL_OUT4(LOW_RAIL_OUT4),
    .MAIN_RAIL_OUT5(MAIN_RAIL_OUT5), .MAIN_RAIL_OUT6(MAIN_RAIL_OUT6));

// ### verif/host_model.sv
// Host that programs the clock generator byte registers.
// Assumes the core's register port on MCLK, one write per strobe cycle.
`timescale 1ns/1ps
module host_model
(
    input  wire logic       MCLK,
    output logic      [7:0] REG_ADDR,
    output logic      [7:0] REG_WDATA,
    output logic            REG_WRITE,
    input  wire logic [7:0] REG_RDATA
);
    initial
    begin
        REG_ADDR  = 8'h00;
        REG_WDATA = 8'h00;
        REG_WRITE = 1'b0;
    end
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge MCLK);
        REG_ADDR  <= addr;
        REG_WDATA <= data;
        REG_WRITE <= 1'b1;
        @(posedge MCLK);
        REG_WRITE <= 1'b0;
        REG_WDATA <= ~data;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge MCLK);
        REG_ADDR <= addr;
        @(posedge MCLK);
        @(negedge MCLK);
        data = REG_RDATA;
    endtask : read_reg
    // Loop setup with a gain code picked from the multiplier total
    task automatic program_loop(input logic [6:0] q, input logic [9:0] base, input logic odd);
        logic [11:0] t;
        logic [2:0]  g;
        t = {1'b0, base, 1'b0} + 12'h008 + {11'h000, odd};
        g = (t < 45) ? 3'h0 : (t < 480) ? 3'h1 : (t < 640) ? 3'h2 : (t < 800) ? 3'h3 : 3'h4;
        write_reg(8'h40, {3'h6, g, base[9:8]});
        write_reg(8'h41, base[7:0]);
        write_reg(8'h42, {odd, q});
    endtask : program_loop
    task automatic program_route(input logic [7:0] b1, input logic [7:0] b2, input logic [17:0] codes,
                                 input logic [5:0] en);
        write_reg(8'h0C, b1);
        write_reg(8'h47, b2);
        write_reg(8'h44, codes[17:10]);
        write_reg(8'h45, codes[9:2]);
        write_reg(8'h46, {codes[1:0], 6'h3F});
        write_reg(8'h09, {2'h0, en});
    endtask : program_route
endmodule : host_model

// ### verif/clock_gen_core_tb.sv
// Self-checking bench for the clock generator core.
// Assumes reference clock of 8 MCLK periods and loop clock of 6 MCLK periods.
`timescale 1ns/1ps
module clock_gen_core_tb;
    import clock_gen_pkg::*;
    logic        MCLK, RESET, REF_CLK, LOOP_CLK, REG_WRITE, PHASE_REFERENCE;
    logic        LOW_RAIL_OUT1, LOW_RAIL_OUT2, LOW_RAIL_OUT3, LOW_RAIL_OUT4, MAIN_RAIL_OUT5, MAIN_RAIL_OUT6;
    logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, INPUT_DIVISION_TOTAL;
    logic [11:0] LOOP_MULTIPLIER_TOTAL;
    logic [2:0]  LOOP_GAIN_CODE;
    logic [6:0]  mon;
    int          err_total;
    int          n_checks;
    assign mon = {PHASE_REFERENCE, MAIN_RAIL_OUT6, MAIN_RAIL_OUT5, LOW_RAIL_OUT4, LOW_RAIL_OUT3, LOW_RAIL_OUT2,
                  LOW_RAIL_OUT1};
    initial MCLK = 1'b0;
    always #25 MCLK = ~MCLK;
    initial REF_CLK = 1'b0;
    always #200 REF_CLK = ~REF_CLK;
    initial LOOP_CLK = 1'b0;
    always #150 LOOP_CLK = ~LOOP_CLK;
    clock_gen_core clock_gen_core_i (.MCLK(MCLK), .RESET(RESET), .REF_CLK(REF_CLK), .LOOP_CLK(LOOP_CLK),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE), .REG_RDATA(REG_RDATA),
        .INPUT_DIVISION_TOTAL(INPUT_DIVISION_TOTAL), .LOOP_MULTIPLIER_TOTAL(LOOP_MULTIPLIER_TOTAL),
        .LOOP_GAIN_CODE(LOOP_GAIN_CODE), .PHASE_REFERENCE(PHASE_REFERENCE), .LOW_RAIL_OUT1(LOW_RAIL_OUT1),
        .LOW_RAIL_OUT2(LOW_RAIL_OUT2), .LOW_RAIL_OUT3(LOW_RAIL_OUT3), .LOW_RAIL_OUT4(LOW_RAIL_OUT4),
        .MAIN_RAIL_OUT5(MAIN_RAIL_OUT5), .MAIN_RAIL_OUT6(MAIN_RAIL_OUT6));
    host_model host_model_i (.MCLK(MCLK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE),
        .REG_RDATA(REG_RDATA));
    // --------
    // Shared helpers
    // --------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Rise-to-rise period of mon[idx]; al: mon[oth] rose at the second rise
    task automatic measure(input int idx, input int oth, output logic [15:0] per, output logic al);
        logic p;
        logic po;
        int   t0;
        per = 16'h0000;
        al = 1'b0;
        t0 = -1;
        @(negedge MCLK);
        p = mon[idx];
        po = mon[oth];
        for (int n = 0; n < 2200 && per == 16'h0000; n++)
        begin
            @(negedge MCLK);
            if (p === 1'b0 && mon[idx] === 1'b1)
            begin
                if (t0 >= 0)
                    per = 16'(n - t0);
                al = (po === 1'b0 && mon[oth] === 1'b1);
                t0 = n;
            end
            p = mon[idx];
            po = mon[oth];
        end
    endtask : measure
    task automatic route_case(input logic [7:0] b1, input logic [7:0] b2, input logic [17:0] codes,
                              input logic [5:0] en, input int exp [6], input int oth [6]);
        logic [15:0] per;
        logic        al;
        host_model_i.program_route(b1, b2, codes, en);
        repeat (100) @(posedge MCLK);
        for (int i = 0; i < 6; i++)
        begin
            measure(i, i, per, al);
            check("output period", per, 16'(exp[i]));
            if (oth[i] >= 0)
            begin
                measure(oth[i], i, per, al);
                check("rising edge alignment", {15'h0000, al}, 16'h0001);
            end
        end
    endtask : route_case
    // --------
    // Scenarios
    // --------
    task automatic t_regs;
        logic [7:0] ra [10] = '{8'h09, 8'h0C, 8'h40, 8'h41, 8'h42, 8'h44, 8'h45, 8'h46, 8'h47, 8'h43};
        logic [7:0] rv [10] = '{8'h00, 8'h08, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h08, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 10; i++)
        begin
            host_model_i.read_reg(ra[i], d);
            check("reset value", {8'h00, d}, {8'h00, rv[i]});
        end
        host_model_i.write_reg(8'h40, 8'hF3);
        host_model_i.write_reg(8'h09, 8'hFF);
        host_model_i.write_reg(8'h43, 8'h55);
        host_model_i.read_reg(8'h40, d);
        check("gain register", {8'h00, d}, 16'h00D3);
        host_model_i.read_reg(8'h09, d);
        check("enable register", {8'h00, d}, 16'h003F);
        host_model_i.read_reg(8'h43, d);
        check("unmapped read", {8'h00, d}, 16'h0000);
    endtask : t_regs
    task automatic t_loop;
        logic [6:0]  q [3] = '{7'h00, 7'h7F, 7'h05};
        logic [9:0]  b [3] = '{10'h000, 10'h3FF, 10'h12C};
        logic        o [3] = '{1'b0, 1'b1, 1'b1};
        logic [15:0] per;
        logic        al;
        for (int i = 0; i < 3; i++)
        begin
            host_model_i.program_loop(q[i], b[i], o[i]);
            repeat (4) @(posedge MCLK);
            @(negedge MCLK);
            check("input total", {8'h00, INPUT_DIVISION_TOTAL}, 16'(q[i]) + 16'h0002);
            check("multiplier total", {4'h0, LOOP_MULTIPLIER_TOTAL}, 16'(2 * (b[i] + 4) + o[i]));
            check("gain code", {13'h0000, LOOP_GAIN_CODE}, (i == 0) ? 16'h0 : (i == 1) ? 16'h4 : 16'h2);
            measure(6, 6, per, al);
            check("phase reference period", per, 16'h0008 * (16'(q[i]) + 16'h0002));
        end
    endtask : t_loop
    task automatic t_cross_ref;
        route_case(8'h84, 8'h88, 18'b000_001_010_100_101_110, 6'h3F, '{8, 32, 16, 64, 16, 32},
                   '{-1, -1, 1, -1, 3, 3});
    endtask : t_cross_ref
    task automatic t_cross_loop;
        route_case(8'h06, 8'h88, 18'b011_001_111_000_011_001, 6'h3F, '{18, 36, 0, 8, 18, 36},
                   '{1, -1, -1, -1, 5, -1});
    endtask : t_cross_loop
    task automatic t_enable;
        route_case(8'h84, 8'h88, 18'b000_001_010_100_101_110, 6'h15, '{8, 0, 16, 0, 16, 0},
                   '{-1, -1, -1, -1, -1, -1});
    endtask : t_enable
    // --------
    // Run control
    // --------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial
    begin
        #2ms;
        err_total++;
        complete_run();
    end
    initial
    begin
        err_total = 0;
        n_checks = 0;
        RESET = 1'b1;
        repeat (5) @(posedge MCLK);
        RESET <= 1'b0;
        t_regs();
        t_loop();
        t_cross_ref();
        t_cross_loop();
        t_enable();
        complete_run();
    end
endmodule : clock_gen_core_tb
